// ==== design/vme_rr_pkg.sv ====
// Purpose: Shared constants and types for VMEbus request and release control.
// Assumes: 10 MHz mclk; APB slave with 32-bit data.
// Notes: Times are kept in ns and converted to whole cycles here.
//
// Function
// - Round-robin: wait for request line release first
// - New master drops its request; waiters keep theirs
// - Request line negated after 20 ns high
// - Own request at least 50 ns after high
// - Request control bit 1 disables round-robin
// - DMA ignores all processor release options
// - DMA releases on source to destination switch
// - Processor releases on request after hold, cycle end
// - Release on request is always active
// - Hold code doubles from 0.5 us to 64 us
// - Bus clear releases after current processor cycle
// - Clear and per-cycle release spare read-modify-write
// - Release control bit 3 disables bus clear release
// - Idle release after hold and 100 us idle
// - Power fail releases unless handler selected
// - Per-cycle release after every processor cycle
// - Cycle release control bit 7 enables per-cycle
// - After release, wait for request line release
// - Request on processor or DMA VMEbus demand
// - No request while power fail pending, not handler
package vme_rr_pkg;
    localparam logic [31:0] RELEASE_CTL_ADDR = 32'hFFD00274;
    localparam logic [31:0] REQUEST_CTL_ADDR = 32'hFFD00278;
    localparam logic [31:0] CYCLE_CTL_ADDR = 32'hFFD0032C;
    localparam logic [31:0] STATUS_ADDR = 32'hFFD00380;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [31:0] DATA_RESET = 32'h00000000;
    localparam logic [23:0] READ_PAD = 24'h000000;
    localparam int HOLD_LSB = 0;
    localparam int HOLD_W = 3;
    localparam int CLEAR_DIS_BIT = 3;
    localparam int ROUND_ROBIN_REQUEST_OPTION_DIS_BIT = 1;
    localparam int HANDLER_BIT = 4;
    localparam int PER_CYCLE_EN_BIT = 7;
    localparam logic [2:0] SEL_RELEASE = 3'h0;
    localparam logic [2:0] SEL_REQUEST = 3'h1;
    localparam logic [2:0] SEL_CYCLE = 3'h2;
    localparam logic [2:0] SEL_STATUS = 3'h3;
    localparam logic [2:0] SEL_NONE = 3'h4;
    localparam int PIN_BR = 0;
    localparam int PIN_CLEAR = 1;
    localparam int PIN_GRANT = 2;
    localparam int PIN_FAIL = 3;
    localparam int PIN_COUNT = 4;
    localparam int CLK_NS = 100;
    localparam int FILTER_NS = 20;
    localparam int GAP_NS = 50;
    localparam int HOLD_BASE_NS = 500;
    localparam int IDLE_NS = 100000;
    localparam int FILTER_CYC = (FILTER_NS + CLK_NS - 1) / CLK_NS;
    localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_BASE_CYC = (HOLD_BASE_NS + CLK_NS - 1) / CLK_NS;
    localparam int IDLE_CYC = (IDLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 10;
    localparam int FILT_W = 3;
    localparam int GAP_W = 3;
    typedef enum logic [2:0] {S_IDLE, S_ROUND, S_GAP, S_REQ, S_OWN} arb_state_t;
endpackage : vme_rr_pkg

// ==== design/interval_if.sv ====
// Purpose: Start, limit and expiry wires between controller and timer.
// Assumes: Single mclk domain.
// Notes: Limit is sampled on start.
`timescale 1ns/100ps
`default_nettype none
interface interval_if #(parameter int W = 10);
    logic start;
    logic [W-1:0] limit;
    logic expired;
    modport user (output start, output limit, input expired);
    modport timer (input start, input limit, output expired);
endinterface : interval_if
`default_nettype wire

// ==== design/pin_sync.sv ====
// Purpose: Three-stage synchroniser for asynchronous pins.
// Assumes: Pins are level signals.
// Notes: Output follows only when stages two and three agree.
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
    parameter int W = 4,
    parameter logic [W-1:0] IDLE_LEVEL = '1
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [W-1:0] pinIn,
    output logic [W-1:0] pinOut
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_t;
    sync_t st_ff;
    sync_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = pinIn;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        for (int i = 0; i < W; i++) begin
            if (st_ff.s2[i] == st_ff.s3[i]) begin
                nxt_st.q[i] = st_ff.s3[i];
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            st_ff <= {IDLE_LEVEL, IDLE_LEVEL, IDLE_LEVEL, IDLE_LEVEL};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pinOut = st_ff.q;
endmodule : pin_sync
`default_nettype wire

// ==== design/interval_timer.sv ====
// Purpose: Down counter that reports expiry after a loaded interval.
// Assumes: Start is a level; held start keeps reloading.
// Notes: Expired stays low until armed once.
`timescale 1ns/100ps
`default_nettype none
module interval_timer #(parameter int W = 10) (
    input wire logic mclk,
    input wire logic reset,
    interval_if.timer tmr
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic armed;
    } timer_t;
    timer_t st_ff;
    timer_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (tmr.start) begin
            nxt_st.cnt = tmr.limit;
            nxt_st.armed = 1'b1;
        end else if (st_ff.cnt != '0) begin
            nxt_st.cnt = st_ff.cnt - 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tmr.expired = st_ff.armed & (st_ff.cnt == '0);
endmodule : interval_timer
`default_nettype wire

// ==== design/vme_bus_request_release.sv ====
// Purpose: VMEbus mastership request and release for processor and DMA.
// Assumes: External arbiter; grant taken on falling edge of grant pin.
// Notes: Registers reached over APB; all pins active low.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module vme_bus_request_release (
    input wire logic mclk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic busRequestInN,
    input wire logic busClearInN,
    input wire logic busGrantInN,
    input wire logic powerFailN,
    input wire logic cpuVmeRequest,
    input wire logic cpuCycleActive,
    input wire logic cpuRmw,
    input wire logic dmaVmeRequest,
    input wire logic dmaPhaseSwitch,
    output logic busRequestOutN,
    output logic busyOutN,
    output logic cpuMaster,
    output logic dmaMaster
);
    typedef struct packed {
        vme_rr_pkg::arb_state_t state;
        logic ownerCpu;
        logic cycleSeen;
        logic brN;
        logic busyN;
        logic cpuM;
        logic dmaM;
        logic grantPrev;
        logic [vme_rr_pkg::FILT_W-1:0] hiCnt;
        logic [vme_rr_pkg::GAP_W-1:0] gapCnt;
        logic [7:0] relCtl;
        logic [7:0] reqCtl;
        logic [7:0] cycCtl;
        logic [31:0] rdata;
        logic ready;
        logic err;
    } ctl_t;

    ctl_t st_ff;
    ctl_t nxt_st;
    logic [vme_rr_pkg::PIN_COUNT-1:0] syncQ;
    logic brHigh;
    logic fairOn;
    logic pfPend;
    logic demand;
    logic grantFell;
    logic gain;
    logic ownCpu;
    logic dmaOwn;
    logic holdExp;
    logic idleExp;
    logic rorHit;
    logic clrHit;
    logic idleHit;
    logic recHit;
    logic cpuRelease;
    logic dmaRelease;
    logic [2:0] wrSel;
    logic [2:0] rdSel;

    interval_if #(.W(vme_rr_pkg::CNT_W)) holdIf ();
    interval_if #(.W(vme_rr_pkg::CNT_W)) idleIf ();

    function automatic logic [2:0] regSel(input logic [31:0] a);
        logic [2:0] s;
        s = vme_rr_pkg::SEL_NONE;
        if (a == vme_rr_pkg::RELEASE_CTL_ADDR) begin
            s = vme_rr_pkg::SEL_RELEASE;
        end else if (a == vme_rr_pkg::REQUEST_CTL_ADDR) begin
            s = vme_rr_pkg::SEL_REQUEST;
        end else if (a == vme_rr_pkg::CYCLE_CTL_ADDR) begin
            s = vme_rr_pkg::SEL_CYCLE;
        end else if (a == vme_rr_pkg::STATUS_ADDR) begin
            s = vme_rr_pkg::SEL_STATUS;
        end
        return s;
    endfunction : regSel

    function automatic logic [vme_rr_pkg::CNT_W-1:0] holdLimit(input logic [2:0] code);
        return vme_rr_pkg::CNT_W'(vme_rr_pkg::HOLD_BASE_CYC) << code;
    endfunction : holdLimit

    pin_sync #(.W(vme_rr_pkg::PIN_COUNT)) pinSync (
        .mclk(mclk),
        .reset(reset),
        .pinIn({powerFailN, busGrantInN, busClearInN, busRequestInN}),
        .pinOut(syncQ)
    );

    interval_timer #(.W(vme_rr_pkg::CNT_W)) holdTimer (
        .mclk(mclk),
        .reset(reset),
        .tmr(holdIf.timer)
    );

    interval_timer #(.W(vme_rr_pkg::CNT_W)) idleTimer (
        .mclk(mclk),
        .reset(reset),
        .tmr(idleIf.timer)
    );

    // Control decode and release conditions
    assign brHigh = st_ff.hiCnt >= vme_rr_pkg::FILT_W'(vme_rr_pkg::FILTER_CYC);
    assign fairOn = !st_ff.reqCtl[vme_rr_pkg::ROUND_ROBIN_REQUEST_OPTION_DIS_BIT];
    assign pfPend = !syncQ[vme_rr_pkg::PIN_FAIL] && !st_ff.reqCtl[vme_rr_pkg::HANDLER_BIT];
    assign demand = (cpuVmeRequest || dmaVmeRequest) && !pfPend;
    assign grantFell = st_ff.grantPrev && !syncQ[vme_rr_pkg::PIN_GRANT];
    assign gain = (st_ff.state == vme_rr_pkg::S_REQ) && grantFell;
    assign ownCpu = (st_ff.state == vme_rr_pkg::S_OWN) && st_ff.ownerCpu;
    assign dmaOwn = (st_ff.state == vme_rr_pkg::S_OWN) && !st_ff.ownerCpu;
    assign holdExp = holdIf.expired;
    assign idleExp = idleIf.expired;
    assign rorHit = !syncQ[vme_rr_pkg::PIN_BR] && holdExp;
    assign clrHit = !st_ff.relCtl[vme_rr_pkg::CLEAR_DIS_BIT]
        && !syncQ[vme_rr_pkg::PIN_CLEAR] && !cpuRmw;
    assign idleHit = holdExp && idleExp;
    assign recHit = st_ff.cycCtl[vme_rr_pkg::PER_CYCLE_EN_BIT]
        && st_ff.cycleSeen && !cpuRmw;
    assign cpuRelease = ownCpu && !cpuCycleActive
        && (rorHit || clrHit || idleHit || pfPend || recHit);
    assign dmaRelease = dmaOwn && (dmaPhaseSwitch || !dmaVmeRequest);
    assign holdIf.start = gain;
    assign holdIf.limit = holdLimit(st_ff.relCtl[vme_rr_pkg::HOLD_LSB +: vme_rr_pkg::HOLD_W]);
    assign idleIf.start = gain || (ownCpu && cpuCycleActive);
    assign idleIf.limit = vme_rr_pkg::CNT_W'(vme_rr_pkg::IDLE_CYC);
    assign wrSel = regSel(paddr);
    assign rdSel = regSel(paddr);

    always_comb begin
        nxt_st = st_ff;
        nxt_st.ready = 1'b0;
        nxt_st.err = 1'b0;
        nxt_st.grantPrev = syncQ[vme_rr_pkg::PIN_GRANT];
        // Filter on the negated request line
        if (!syncQ[vme_rr_pkg::PIN_BR]) begin
            nxt_st.hiCnt = '0;
        end else if (!brHigh) begin
            nxt_st.hiCnt = st_ff.hiCnt + 1'b1;
        end
        // APB: answer one cycle into access, commit at the ready edge
        if (psel && penable && !st_ff.ready) begin
            nxt_st.ready = 1'b1;
            nxt_st.err = (rdSel == vme_rr_pkg::SEL_NONE);
            unique case (rdSel)
                vme_rr_pkg::SEL_RELEASE: nxt_st.rdata = {vme_rr_pkg::READ_PAD, st_ff.relCtl};
                vme_rr_pkg::SEL_REQUEST: nxt_st.rdata = {vme_rr_pkg::READ_PAD, st_ff.reqCtl};
                vme_rr_pkg::SEL_CYCLE: nxt_st.rdata = {vme_rr_pkg::READ_PAD, st_ff.cycCtl};
                vme_rr_pkg::SEL_STATUS: nxt_st.rdata = {vme_rr_pkg::READ_PAD,
                    st_ff.cycleSeen, st_ff.ownerCpu, st_ff.busyN, st_ff.brN, brHigh,
                    st_ff.state};
                default: nxt_st.rdata = vme_rr_pkg::DATA_RESET;
            endcase
        end
        if (psel && penable && st_ff.ready && pwrite) begin
            unique case (wrSel)
                vme_rr_pkg::SEL_RELEASE: nxt_st.relCtl = pwdata[7:0];
                vme_rr_pkg::SEL_REQUEST: nxt_st.reqCtl = pwdata[7:0];
                vme_rr_pkg::SEL_CYCLE: nxt_st.cycCtl = pwdata[7:0];
                default: nxt_st.relCtl = st_ff.relCtl;
            endcase
        end
        if (ownCpu && cpuCycleActive) begin
            nxt_st.cycleSeen = 1'b1;
        end
        // Mastership sequence
        unique case (st_ff.state)
            vme_rr_pkg::S_IDLE: begin
                if (demand) begin
                    nxt_st.state = fairOn ? vme_rr_pkg::S_ROUND : vme_rr_pkg::S_REQ;
                end
            end
            vme_rr_pkg::S_ROUND: begin
                if (!demand) begin
                    nxt_st.state = vme_rr_pkg::S_IDLE;
                end else if (brHigh) begin
                    nxt_st.state = vme_rr_pkg::S_GAP;
                    nxt_st.gapCnt = '0;
                end
            end
            vme_rr_pkg::S_GAP: begin
                nxt_st.gapCnt = st_ff.gapCnt + 1'b1;
                if (!demand) begin
                    nxt_st.state = vme_rr_pkg::S_IDLE;
                end else if (nxt_st.gapCnt >= vme_rr_pkg::GAP_W'(vme_rr_pkg::GAP_CYC)) begin
                    nxt_st.state = vme_rr_pkg::S_REQ;
                end
            end
            vme_rr_pkg::S_REQ: begin
                if (gain) begin
                    nxt_st.state = vme_rr_pkg::S_OWN;
                    nxt_st.ownerCpu = cpuVmeRequest;
                    nxt_st.cycleSeen = 1'b0;
                end else if (!demand) begin
                    nxt_st.state = vme_rr_pkg::S_IDLE;
                end
            end
            vme_rr_pkg::S_OWN: begin
                if (cpuRelease || dmaRelease) begin
                    nxt_st.state = vme_rr_pkg::S_IDLE;
                end
            end
        endcase
        nxt_st.brN = (nxt_st.state != vme_rr_pkg::S_REQ);
        nxt_st.busyN = (nxt_st.state != vme_rr_pkg::S_OWN);
        nxt_st.cpuM = !nxt_st.busyN && nxt_st.ownerCpu;
        nxt_st.dmaM = !nxt_st.busyN && !nxt_st.ownerCpu;
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            st_ff <= '{state: vme_rr_pkg::S_IDLE, ownerCpu: 1'b0, cycleSeen: 1'b0,
                brN: 1'b1, busyN: 1'b1, cpuM: 1'b0, dmaM: 1'b0, grantPrev: 1'b1,
                hiCnt: '0, gapCnt: '0, relCtl: vme_rr_pkg::CTL_RESET,
                reqCtl: vme_rr_pkg::CTL_RESET, cycCtl: vme_rr_pkg::CTL_RESET,
                rdata: vme_rr_pkg::DATA_RESET, ready: 1'b0, err: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata = st_ff.rdata;
    assign pready = st_ff.ready;
    assign pslverr = st_ff.err;
    assign busRequestOutN = st_ff.brN;
    assign busyOutN = st_ff.busyN;
    assign cpuMaster = st_ff.cpuM;
    assign dmaMaster = st_ff.dmaM;

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    sequence s_gain;
        st_ff.state == vme_rr_pkg::S_REQ ##1 st_ff.state == vme_rr_pkg::S_OWN;
    endsequence

    property p_fairStart;
        $fell(st_ff.brN) && $past(fairOn) |-> $past(st_ff.state) == vme_rr_pkg::S_GAP;
    endproperty
    a_fairStart: assert property (p_fairStart) else $error("request without new round");

    property p_dropOnGain;
        $fell(st_ff.busyN) |-> st_ff.brN && $past(!st_ff.brN);
    endproperty
    a_dropOnGain: assert property (p_dropOnGain) else $error("request kept as master");

    property p_filter;
        $rose(brHigh) |-> $past(syncQ[vme_rr_pkg::PIN_BR]);
    endproperty
    a_filter: assert property (p_filter) else $error("negation seen too early");

    property p_gap;
        $rose(st_ff.state == vme_rr_pkg::S_GAP) |-> st_ff.brN && $past(brHigh);
    endproperty
    a_gap: assert property (p_gap) else $error("gap entered wrongly");

    property p_dmaKeep;
        dmaOwn && dmaVmeRequest && !dmaPhaseSwitch |=> !st_ff.busyN;
    endproperty
    a_dmaKeep: assert property (p_dmaKeep) else $error("DMA released early");

    property p_dmaSwitch;
        dmaOwn && dmaPhaseSwitch |=> st_ff.busyN && st_ff.state == vme_rr_pkg::S_IDLE;
    endproperty
    a_dmaSwitch: assert property (p_dmaSwitch) else $error("DMA kept bus on switch");

    property p_cycleEnd;
        $rose(st_ff.busyN) && $past(st_ff.ownerCpu) |-> !$past(cpuCycleActive);
    endproperty
    a_cycleEnd: assert property (p_cycleEnd) else $error("released mid cycle");

    property p_holdStart;
        s_gain |-> !holdExp ##1 !holdExp;
    endproperty
    a_holdStart: assert property (p_holdStart) else $error("hold expired at gain");

    property p_clear;
        ownCpu && clrHit && !cpuCycleActive |=> st_ff.busyN;
    endproperty
    a_clear: assert property (p_clear) else $error("bus clear ignored");

    property p_rmw;
        $rose(st_ff.busyN) && $past(st_ff.ownerCpu) && $past(cpuRmw)
            |-> $past(rorHit || idleHit || pfPend);
    endproperty
    a_rmw: assert property (p_rmw) else $error("RMW sequence broken");

    property p_perCycle;
        ownCpu && recHit && !cpuCycleActive |=> st_ff.busyN;
    endproperty
    a_perCycle: assert property (p_perCycle) else $error("per-cycle release missed");

    property p_powerFail;
        pfPend && st_ff.state == vme_rr_pkg::S_IDLE |=> st_ff.brN;
    endproperty
    a_powerFail: assert property (p_powerFail) else $error("request during power fail");
endmodule : vme_bus_request_release
`default_nettype wire

// ==== test/vme_far_side.sv ====
// Purpose: Other VMEbus requesters and the external grant arbiter.
// Assumes: Shared request line is wired low with a pull-up.
// Notes: Grant falls grantDelay plus one cycles after a request; rises on busy.
`timescale 1ns/100ps
`default_nettype none
module vme_far_side (
    input wire logic mclk,
    input wire logic reset,
    input wire logic busRequestOutN,
    input wire logic busyOutN,
    input wire logic otherReq,
    input wire logic [3:0] grantDelay,
    output logic busRequestInN,
    output logic busGrantInN
);
    logic [3:0] waitCnt;
    // Waiting requesters keep the line low
    assign busRequestInN = busRequestOutN & ~otherReq;
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            waitCnt <= 4'h0;
            busGrantInN <= 1'b1;
        end else if (busyOutN == 1'b0 || busRequestOutN == 1'b1) begin
            waitCnt <= 4'h0;
            busGrantInN <= 1'b1;
        end else if (waitCnt >= grantDelay) begin
            busGrantInN <= 1'b0;
        end else begin
            waitCnt <= waitCnt + 4'h1;
        end
    end
endmodule : vme_far_side
`default_nettype wire

// ==== test/vme_bus_request_release_bench.sv ====
// Purpose: Self-checking bench for VMEbus request and release control.
// Assumes: Far-side model grants after a random delay.
// Notes: Cycle windows allow for the three-flop pin synchroniser.
`timescale 1ns/100ps
`default_nettype none
module vme_bus_request_release_bench;
    logic mclk, reset, psel, penable, pwrite, pready, pslverr, err;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic busRequestInN, busClearInN, busGrantInN, powerFailN, otherReq;
    logic cpuVmeRequest, cpuCycleActive, cpuRmw, dmaVmeRequest, dmaPhaseSwitch;
    logic busRequestOutN, busyOutN, cpuMaster, dmaMaster;
    logic [3:0] grantDelay;
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    int n;
    int regs[3];
    logic [31:0] addrs[3];
    vme_bus_request_release u_vme_bus_request_release (.mclk, .reset, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .busRequestInN, .busClearInN,
        .busGrantInN, .powerFailN, .cpuVmeRequest, .cpuCycleActive, .cpuRmw, .dmaVmeRequest,
        .dmaPhaseSwitch, .busRequestOutN, .busyOutN, .cpuMaster, .dmaMaster);
    vme_far_side u_vme_far_side (.mclk, .reset, .busRequestOutN, .busyOutN, .otherReq,
        .grantDelay, .busRequestInN, .busGrantInN);
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task automatic give_verdict();
        $display("Counts: compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            give_verdict();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check
    task automatic span(input int v, input int lo, input int hi);
        check(32'(v >= lo && v <= hi), 32'h1);
    endtask : span
    task automatic apb(input logic isWrite, input logic [31:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= isWrite;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb
    task automatic regWrite(input int i, input logic [31:0] v);
        apb(1'b1, addrs[i], v);
        regs[i] = int'(v & 32'hFF);
    endtask : regWrite
    task automatic regRead(input int i);
        apb(1'b0, addrs[i], 32'h0);
        check(rd, 32'(regs[i]));
        check(32'(err), 32'h0);
    endtask : regRead
    task automatic stays(input int c, input logic useBusy);
        logic bad;
        bad = 1'b0;
        repeat (c) begin
            @(posedge mclk);
            if (useBusy) bad |= (busyOutN !== 1'b0);
            else bad |= (busRequestOutN !== 1'b1);
        end
        check(32'(bad), 32'h0);
    endtask : stays
    task automatic waitUntil(input logic useBusy, output int k);
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while ((useBusy ? busyOutN !== 1'b1 : busRequestOutN !== 1'b0) && k < 3000);
    endtask : waitUntil
    task automatic gain(input logic cpu);
        int k;
        grantDelay <= 4'($urandom_range(0, 7));
        cpuVmeRequest <= cpu;
        dmaVmeRequest <= ~cpu;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (busyOutN !== 1'b0 && k < 200);
        check({29'h0, cpuMaster, dmaMaster, busRequestOutN}, {29'h0, cpu, ~cpu, 1'b1});
    endtask : gain
    task automatic settle();
        cpuVmeRequest <= 1'b0;
        dmaVmeRequest <= 1'b0;
        otherReq <= 1'b0;
        busClearInN <= 1'b1;
        powerFailN <= 1'b1;
        cpuCycleActive <= 1'b0;
        cpuRmw <= 1'b0;
        repeat (10) @(posedge mclk);
        $display("Test step done at %0t", $time);
    endtask : settle
    task automatic cpuPulse();
        cpuCycleActive <= 1'b1;
        @(posedge mclk);
        cpuCycleActive <= 1'b0;
    endtask : cpuPulse
    initial begin
        addrs = '{vme_rr_pkg::RELEASE_CTL_ADDR, vme_rr_pkg::REQUEST_CTL_ADDR,
            vme_rr_pkg::CYCLE_CTL_ADDR};
        regs = '{0, 0, 0};
        reset = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {busClearInN, powerFailN} = 2'h3;
        {cpuVmeRequest, cpuCycleActive, cpuRmw, dmaVmeRequest, dmaPhaseSwitch} = '0;
        otherReq = 1'b0;
        grantDelay = 4'h2;
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        void'($urandom(32'hC130FF37));
        for (int i = 0; i < 3; i++) begin
            regRead(i);
            regWrite(i, $urandom);
            regRead(i);
            regWrite(i, 32'h0);
        end
        apb(1'b1, 32'hFFD00270, 32'hFF);
        check(32'(err), 32'h1);
        apb(1'b0, 32'hFFD00270, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, vme_rr_pkg::STATUS_ADDR, 32'h0);
        check(rd, 32'h38);
        $display("Test registers done");
        // Round-robin wait, then release on request for every hold code
        otherReq <= 1'b1;
        repeat (6) @(posedge mclk);
        cpuVmeRequest <= 1'b1;
        stays(20, 1'b0);
        otherReq <= 1'b0;
        waitUntil(1'b0, n);
        span(n, 2, 12);
        for (int c = 0; c < 8; c++) begin
            if (c > 0) regWrite(0, 32'(c));
            gain(1'b1);
            otherReq <= 1'b1;
            waitUntil(1'b1, n);
            span(n, (5 << c) - 1, (5 << c) + 8);
            stays(10, 1'b0);
            settle();
        end
        regWrite(0, 32'h0);
        // Bus clear deferred by cycle and read-modify-write
        gain(1'b1);
        busClearInN <= 1'b0;
        cpuRmw <= 1'b1;
        cpuCycleActive <= 1'b1;
        stays(15, 1'b1);
        cpuCycleActive <= 1'b0;
        stays(10, 1'b1);
        cpuRmw <= 1'b0;
        waitUntil(1'b1, n);
        span(n, 1, 6);
        settle();
        // Bus clear disabled, then per-cycle release
        regWrite(0, 32'h08);
        gain(1'b1);
        busClearInN <= 1'b0;
        stays(30, 1'b1);
        regWrite(2, 32'h80);
        cpuPulse();
        waitUntil(1'b1, n);
        span(n, 1, 6);
        settle();
        regWrite(0, 32'h0);
        regWrite(2, 32'h0);
        // Idle release restarted by an access
        gain(1'b1);
        repeat (500) @(posedge mclk);
        cpuPulse();
        waitUntil(1'b1, n);
        span(n, 995, 1010);
        settle();
        // Power fail release and no request while pending
        gain(1'b1);
        powerFailN <= 1'b0;
        waitUntil(1'b1, n);
        span(n, 1, 6);
        stays(20, 1'b0);
        settle();
        // Round-robin off requests at once
        regWrite(1, 32'h02);
        otherReq <= 1'b1;
        cpuVmeRequest <= 1'b1;
        waitUntil(1'b0, n);
        span(n, 1, 6);
        gain(1'b1);
        otherReq <= 1'b0;
        powerFailN <= 1'b0;
        waitUntil(1'b1, n);
        span(n, 1, 6);
        settle();
        regWrite(1, 32'h0);
        // DMA ignores processor options, releases on phase switch
        regWrite(2, 32'h80);
        gain(1'b0);
        busClearInN <= 1'b0;
        otherReq <= 1'b1;
        cpuPulse();
        stays(40, 1'b1);
        dmaPhaseSwitch <= 1'b1;
        @(posedge mclk);
        dmaPhaseSwitch <= 1'b0;
        waitUntil(1'b1, n);
        span(n, 1, 4);
        settle();
        give_verdict();
    end
endmodule : vme_bus_request_release_bench
`default_nettype wire
